// >>> verilog/hvi_pkg.sv
// Constants, command codes and state type for the high voltage register interpreter
package hvi_pkg;

    // ----------------------------------------------------------------
    // Clock and link timing
    // ----------------------------------------------------------------
    localparam int          HVI_CLK_HZ    = 25_000_000;  // System clock rate
    localparam int          HVI_LINK_HZ   = 2_560_000;   // Highest serial clock rate
    // Half period, rounded up so the link never runs faster than allowed
    localparam int          HVI_HALF_CYC  = (HVI_CLK_HZ + 2 * HVI_LINK_HZ - 1) / (2 * HVI_LINK_HZ);
    localparam logic [3:0]  HVI_HALF_LAST = 4'(HVI_HALF_CYC - 1);
    localparam int          HVI_LAT_US    = 10;          // Longest command latency, us
    // Longest latency in cycles, rounded down
    localparam int          HVI_LAT_CYC   = HVI_LAT_US * (HVI_CLK_HZ / 1_000_000);

    // ----------------------------------------------------------------
    // Register map (byte addresses)
    // ----------------------------------------------------------------
    localparam logic [31:0] HVI_ADDR_CMD  = 32'hffff0804; // Command / status register
    localparam logic [31:0] HVI_ADDR_DAT  = 32'hffff080c; // Data register
    localparam logic [11:0] HVI_DAT_RST   = 12'h000;      // Data register reset value
    localparam int          HVI_BUSY_BIT  = 0;            // Status: busy
    localparam int          HVI_RDOK_BIT  = 1;            // Status: read-back succeeded
    localparam int          HVI_TXOK_BIT  = 2;            // Status: command sent
    localparam int          HVI_TAG_LSB   = 8;            // Command tag field low bit
    localparam int          HVI_TAG_MSB   = 11;           // Command tag field high bit
    localparam logic [2:0]  HVI_BIT_LAST  = 3'h7;         // First bit index of a byte

    // ----------------------------------------------------------------
    // Command codes
    // ----------------------------------------------------------------
    localparam logic [7:0]  HVI_RD_CFG_A  = 8'h00;
    localparam logic [7:0]  HVI_RD_CFG_B  = 8'h01;
    localparam logic [7:0]  HVI_RD_STAT   = 8'h02;
    localparam logic [7:0]  HVI_RD_MON    = 8'h03;
    localparam logic [7:0]  HVI_WR_CFG_A  = 8'h08;
    localparam logic [7:0]  HVI_WR_CFG_B  = 8'h09;

    // Link sequencer states, Gray along the frame
    typedef enum logic [2:0]
    {
        HVI_IDLE  = 3'b000,
        HVI_CMD   = 3'b001,
        HVI_ACK_C = 3'b011,
        HVI_DATA  = 3'b010,
        HVI_ACK_D = 3'b110
    } hvi_state_t;

endpackage

// >>> verilog/hvi_sync2.sv
// Two flip-flop synchroniser for one level
`timescale 1ns/1ps
module hvi_sync2
(
    input  wire logic clk_sys,
    input  wire logic rst,
    input  wire logic d_async,
    output logic      q_sync
);

    logic meta_reg;  // First stage, read only by second stage
    logic sync_reg;  // Second stage
    logic meta_next;
    logic sync_next;

    // Next values of both stages
    always_comb
    begin
        meta_next = d_async;
        sync_next = meta_reg;
    end

    // Register both stages
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            meta_reg <= 1'b0;
            sync_reg <= 1'b0;
        end
        else
        begin
            meta_reg <= meta_next;
            sync_reg <= sync_next;
        end
    end

    assign q_sync = sync_reg;

endmodule

// >>> verilog/hvi_bitclk.sv
// Serial clock divider with bit timing strobes
`timescale 1ns/1ps
module hvi_bitclk
    import hvi_pkg::*;
(
    input  wire logic clk_sys,
    input  wire logic rst,
    input  wire logic run,
    output logic      sclk,
    output logic      bit_end
);

    logic [3:0] cnt_reg;    // Cycles in current half period
    logic [3:0] cnt_next;
    logic       high_reg;   // Serial clock level
    logic       high_next;
    logic       last;       // Half period ends this cycle

    assign last    = run && (cnt_reg == HVI_HALF_LAST);
    assign bit_end = last && high_reg;

    // Count half periods, park low when stopped
    always_comb
    begin
        cnt_next  = cnt_reg + 4'h1;
        high_next = high_reg;
        if (!run)
        begin
            cnt_next  = 4'h0;
            high_next = 1'b0;
        end
        else if (last)
        begin
            cnt_next  = 4'h0;
            high_next = !high_reg;
        end
    end

    // Register divider state
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            cnt_reg  <= 4'h0;
            high_reg <= 1'b0;
        end
        else
        begin
            cnt_reg  <= cnt_next;
            high_reg <= high_next;
        end
    end

    assign sclk = high_reg;

endmodule

// >>> verilog/hvi_ctrl.sv
// High voltage indirect register interpreter with Avalon-MM slave and serial link
//
// Summary of operation
// RULE_01: Codes 0x00-0x03 read four indirect registers.
// RULE_02: Codes 0x08/0x09 write data byte to configs.
// RULE_03: Two-wire serial link, clock at 2.56 MHz; the divider runs it at 2.5 MHz.
// RULE_04: Command reaches far side within 10 us.
// RULE_05: Read data lands in data register within 10 us.
// RULE_06: Command bit 0 reads busy flag.
// RULE_07: Software waits for busy low before commanding.
// RULE_08: Command bit 2 reads transmit success.
// RULE_09: Command bit 1 reads read-back success.
// RULE_10: Status bits meaningful only when not busy.
// RULE_11: Data register 12 bits, low byte data.
// RULE_12: Data bits 11:8 show owning command, read only.
// RULE_13: Software writes zeros into tag bits.
// RULE_14: Exactly four indirect registers, two writable.
// RULE_15: Unknown codes start nothing, change nothing.
`timescale 1ns/1ps
module hvi_ctrl
    import hvi_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        rst,
    // Avalon-MM slave
    input  wire logic [31:0] address,
    input  wire logic        read,
    input  wire logic        write,
    input  wire logic [3:0]  byteenable,
    input  wire logic [31:0] writedata,
    output logic [31:0]      readdata,
    output logic             waitrequest,
    // Serial link to the high voltage side
    output logic             hv_sclk,
    output logic             hv_sdata_out,
    output logic             hv_sdata_oe,
    input  wire logic        hv_sdata_in
);

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    localparam int CHK_LAT = HVI_LAT_CYC;  // Latency bound for checks

    hvi_state_t  state_reg;        // Link sequencer state
    hvi_state_t  state_next;
    logic [2:0]  bit_reg;          // Bit index within byte
    logic [2:0]  bit_next;
    logic [7:0]  shift_reg;        // Serial shift register
    logic [7:0]  shift_next;
    logic [7:0]  cmd_reg;          // Command in progress
    logic [7:0]  cmd_next;
    logic        out_reg;          // Data line drive value
    logic        out_next;
    logic        oe_reg;           // Data line drive enable
    logic        oe_next;
    logic        txok_reg;         // Command sent status
    logic        txok_next;
    logic        rdok_reg;         // Read-back status
    logic        rdok_next;
    logic [11:0] dat_reg;          // Data register with tag
    logic [11:0] dat_next;
    logic        ack_reg;          // Bus answer cycle
    logic        ack_next;
    logic [31:0] rdata_reg;        // Registered read data
    logic [31:0] rdata_next;
    logic        busy;             // Command in progress
    logic        sel_cmd;          // Command register addressed
    logic        sel_dat;          // Data register addressed
    logic        cmd_wr;           // Accepted write to command register
    logic        dat_wr;           // Accepted write to data register
    logic        cmd_known;        // Written code is a defined command
    logic        cmd_go;           // Start a link frame
    logic        is_write;         // Frame carries a write
    logic        bit_end;          // Serial bit period ends
    logic        din_s;            // Synchronised incoming data

    // ----------------------------------------------------------------
    // Submodules
    // ----------------------------------------------------------------
    // Serial clock and bit strobe
    hvi_bitclk u_bitclk
    (
        .clk_sys (clk_sys),
        .rst     (rst),
        .run     (busy),
        .sclk    (hv_sclk),
        .bit_end (bit_end)
    );

    // Incoming data line crosses into clk_sys
    hvi_sync2 u_sync_din
    (
        .clk_sys (clk_sys),
        .rst     (rst),
        .d_async (hv_sdata_in),
        .q_sync  (din_s)
    );

    // ----------------------------------------------------------------
    // Bus decode
    // ----------------------------------------------------------------
    assign busy     = (state_reg != HVI_IDLE);
    assign is_write = cmd_reg[3];

    // Address decode
    always_comb
    begin
        sel_cmd = 1'b0;
        sel_dat = 1'b0;
        if (address == HVI_ADDR_CMD)
        begin
            sel_cmd = 1'b1;
        end
        else if (address == HVI_ADDR_DAT)
        begin
            sel_dat = 1'b1;
        end
    end

    // Only the six defined codes are commands [RULE_14]
    always_comb
    begin
        case (writedata[7:0])
            HVI_RD_CFG_A, HVI_RD_CFG_B, HVI_RD_STAT, HVI_RD_MON,
            HVI_WR_CFG_A, HVI_WR_CFG_B: cmd_known = 1'b1;
            default:                    cmd_known = 1'b0;
        endcase
    end

    // Writes take effect in the answer cycle; busy refuses them
    assign cmd_wr = write && ack_reg && sel_cmd && byteenable[0] && !busy;
    assign dat_wr = write && ack_reg && sel_dat && byteenable[0] && !busy;
    // Unknown codes never start a frame [RULE_15]
    assign cmd_go = cmd_wr && cmd_known;

    // One wait cycle per access, read data ready in answer cycle
    always_comb
    begin
        ack_next   = (read || write) && !ack_reg;
        rdata_next = rdata_reg;
        if (read && !ack_reg)
        begin
            rdata_next = 32'h0000_0000;
            if (sel_cmd)
            begin
                // Status view of command register [RULE_06] [RULE_08] [RULE_09]
                rdata_next[HVI_BUSY_BIT] = busy;
                rdata_next[HVI_RDOK_BIT] = rdok_reg;
                rdata_next[HVI_TXOK_BIT] = txok_reg;
            end
            else if (sel_dat)
            begin
                // Twelve bits, upper bits zero [RULE_11]
                rdata_next[HVI_TAG_MSB:0] = dat_reg;
            end
        end
    end

    // Register bus answer state
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            ack_reg   <= 1'b0;
            rdata_reg <= 32'h0000_0000;
        end
        else
        begin
            ack_reg   <= ack_next;
            rdata_reg <= rdata_next;
        end
    end

    assign waitrequest = (read || write) && !ack_reg;
    assign readdata    = rdata_reg;

    // ----------------------------------------------------------------
    // Link sequencer
    // ----------------------------------------------------------------
    // Frame: 8 command bits out, ack in, 8 data bits, ack in
    always_comb
    begin
        state_next = state_reg;
        bit_next   = bit_reg;
        shift_next = shift_reg;
        cmd_next   = cmd_reg;
        out_next   = out_reg;
        oe_next    = oe_reg;
        txok_next  = txok_reg;
        rdok_next  = rdok_reg;
        dat_next   = dat_reg;
        // Software writes the data byte only; tag is read only [RULE_12]
        if (dat_wr)
        begin
            dat_next[7:0] = writedata[7:0];
        end
        case (state_reg)
            HVI_IDLE:
            begin
                out_next = 1'b0;
                oe_next  = 1'b0;
                if (cmd_go)
                begin
                    // Send command code first [RULE_01] [RULE_03]
                    state_next = HVI_CMD;
                    cmd_next   = writedata[7:0];
                    shift_next = {writedata[6:0], 1'b0};
                    out_next   = writedata[7];
                    oe_next    = 1'b1;
                    bit_next   = HVI_BIT_LAST;
                    // Old status is void while busy [RULE_10]
                    txok_next  = 1'b0;
                    rdok_next  = 1'b0;
                    if (writedata[3])
                    begin
                        // Written byte now belongs to this command [RULE_12]
                        dat_next[HVI_TAG_MSB:HVI_TAG_LSB] = writedata[3:0];
                    end
                end
            end
            HVI_CMD:
            begin
                if (bit_end)
                begin
                    if (bit_reg == 3'h0)
                    begin
                        // Release line for far side acknowledge
                        state_next = HVI_ACK_C;
                        oe_next    = 1'b0;
                        out_next   = 1'b0;
                    end
                    else
                    begin
                        bit_next   = bit_reg - 3'h1;
                        out_next   = shift_reg[7];
                        shift_next = {shift_reg[6:0], 1'b0};
                    end
                end
            end
            HVI_ACK_C:
            begin
                if (bit_end)
                begin
                    // Command transmit outcome [RULE_08]
                    txok_next  = din_s;
                    state_next = HVI_DATA;
                    bit_next   = HVI_BIT_LAST;
                    if (is_write)
                    begin
                        // Drive data byte to config register [RULE_02]
                        oe_next    = 1'b1;
                        out_next   = dat_reg[7];
                        shift_next = {dat_reg[6:0], 1'b0};
                    end
                    else
                    begin
                        shift_next = 8'h00;
                    end
                end
            end
            HVI_DATA:
            begin
                if (bit_end)
                begin
                    if (is_write)
                    begin
                        out_next   = shift_reg[7];
                        shift_next = {shift_reg[6:0], 1'b0};
                    end
                    else
                    begin
                        // Collect read byte, MSB first
                        shift_next = {shift_reg[6:0], din_s};
                    end
                    if (bit_reg == 3'h0)
                    begin
                        state_next = HVI_ACK_D;
                        oe_next    = 1'b0;
                        out_next   = 1'b0;
                    end
                    else
                    begin
                        bit_next = bit_reg - 3'h1;
                    end
                end
            end
            HVI_ACK_D:
            begin
                if (bit_end)
                begin
                    // Read-back outcome, frame done [RULE_09] [RULE_04]
                    rdok_next  = din_s;
                    state_next = HVI_IDLE;
                    if (!is_write && txok_reg && din_s)
                    begin
                        // Load read value and its tag [RULE_05] [RULE_12]
                        dat_next = {cmd_reg[3:0], shift_reg};
                    end
                end
            end
            default:
            begin
                state_next = HVI_IDLE;
                oe_next    = 1'b0;
                out_next   = 1'b0;
            end
        endcase
    end

    // Register sequencer and data state
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            state_reg <= HVI_IDLE;
            bit_reg   <= 3'h0;
            shift_reg <= 8'h00;
            cmd_reg   <= 8'h00;
            out_reg   <= 1'b0;
            oe_reg    <= 1'b0;
            txok_reg  <= 1'b0;
            rdok_reg  <= 1'b0;
            dat_reg   <= HVI_DAT_RST;
        end
        else
        begin
            state_reg <= state_next;
            bit_reg   <= bit_next;
            shift_reg <= shift_next;
            cmd_reg   <= cmd_next;
            out_reg   <= out_next;
            oe_reg    <= oe_next;
            txok_reg  <= txok_next;
            rdok_reg  <= rdok_next;
            dat_reg   <= dat_next;
        end
    end

    assign hv_sdata_out = out_reg;
    assign hv_sdata_oe  = oe_reg;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    // Accepted command
    sequence s_start;
        cmd_go;
    endsequence

    // Last acknowledge of a good read
    sequence s_read_done;
        state_reg == HVI_ACK_D && bit_end && !is_write && txok_reg && din_s;
    endsequence

    chk_cmd_first_bit: assert property (s_start |=> hv_sdata_oe && hv_sdata_out == $past(writedata[7])) // [RULE_01]
        else $error("command frame did not start with code MSB");

    chk_write_drive: assert property ((state_reg == HVI_DATA && is_write) |-> hv_sdata_oe) // [RULE_02]
        else $error("write data not driven");

    chk_link_quiet: assert property (!busy |-> !hv_sclk && !hv_sdata_oe) // [RULE_03]
        else $error("link active while idle");

    chk_frame_bound: assert property (s_start |=> busy ##[1:CHK_LAT] !busy) // [RULE_04]
        else $error("command exceeded latency");

    chk_read_load: assert property (s_read_done |=> dat_reg[7:0] == $past(shift_reg)) // [RULE_05]
        else $error("read byte not loaded");

    chk_busy_set: assert property (s_start |=> busy[*3]) // [RULE_06]
        else $error("busy not raised after command");

    chk_tx_status: assert property ((state_reg == HVI_ACK_C && bit_end) |=> txok_reg == $past(din_s)) // [RULE_08]
        else $error("transmit status wrong");

    chk_rd_status: assert property ((state_reg == HVI_ACK_D && bit_end) |=> rdok_reg == $past(din_s)) // [RULE_09]
        else $error("read status wrong");

    chk_tag_read: assert property (s_read_done |=> dat_reg[11:8] == cmd_reg[3:0]) // [RULE_12]
        else $error("tag does not match command");

    chk_bad_code: assert property ((cmd_wr && !cmd_known) |=> !busy && $stable(dat_reg)) // [RULE_15]
        else $error("unknown code changed state");

endmodule

// >>> verification/hvi_far_model.sv
// Model of the high voltage side: four indirect registers behind the link
`timescale 1ns/1ps
module hvi_far_model
#(
    parameter logic [7:0] STAT_VAL = 8'h3c,  // Status register contents, plain default
    parameter logic [7:0] MON_VAL  = 8'hc3   // Monitor register contents, plain default
)
(
    input  wire logic  rst,
    input  wire logic  hv_sclk,
    input  wire logic  hv_line,
    input  wire logic  fail_tx,
    input  wire logic  fail_rd,
    output logic       drv_oe,
    output logic       drv_val,
    output logic [7:0] cfg_a,
    output logic [7:0] cfg_b,
    output logic [7:0] last_cmd,
    output int         n_frames
);
    // ----------------------------------------------------------------
    // Frame state
    // ----------------------------------------------------------------
    int         bit_cnt;  // Bits seen in this frame
    logic [7:0] cmd_sr;   // Incoming command byte
    logic [7:0] dat_sr;   // Incoming write data byte
    logic [7:0] rd_val;   // Byte returned for a read

    // Sample line on each rising serial clock
    always @(posedge hv_sclk or posedge rst)
    begin
        if (rst)
        begin
            bit_cnt  = 0;
            cfg_a    = 8'h00;
            cfg_b    = 8'h00;
            last_cmd = 8'h00;
            n_frames = 0;
        end
        else
        begin
            if (bit_cnt < 8)
                cmd_sr = {cmd_sr[6:0], hv_line};  // MSB first
            else if (bit_cnt >= 9 && bit_cnt < 17)
                dat_sr = {dat_sr[6:0], hv_line};
            bit_cnt = bit_cnt + 1;
            if (bit_cnt == 18)
            begin
                last_cmd = cmd_sr;
                n_frames = n_frames + 1;
                // Only the two config registers take writes
                if (!fail_tx && cmd_sr == 8'h08)
                    cfg_a = dat_sr;
                else if (!fail_tx && cmd_sr == 8'h09)
                    cfg_b = dat_sr;
            end
        end
    end

    // Drive bits while clock low, release after frame
    always @(negedge hv_sclk or posedge rst)
    begin
        if (rst)
        begin
            drv_oe  = 1'b0;
            drv_val = 1'b0;
        end
        else if (bit_cnt == 8)
        begin
            // Select one of four registers for the read-back
            case (cmd_sr[1:0])
                2'h0:    rd_val = cfg_a;
                2'h1:    rd_val = cfg_b;
                2'h2:    rd_val = STAT_VAL;
                default: rd_val = MON_VAL;
            endcase
            drv_oe  = 1'b1;
            drv_val = !fail_tx;
        end
        else if (bit_cnt >= 9 && bit_cnt < 17 && !cmd_sr[3])
        begin
            drv_oe  = 1'b1;
            drv_val = rd_val[16 - bit_cnt];
        end
        else if (bit_cnt == 17)
        begin
            drv_oe  = 1'b1;
            drv_val = !fail_rd;
        end
        else
        begin
            // Released line falls to the pull-down level
            drv_oe  = 1'b0;
            drv_val = 1'b0;
            if (bit_cnt == 18)
                bit_cnt = 0;
        end
    end
endmodule

// >>> verification/hv_indirect_register_access_bench.sv
// Self-checking bench for the high voltage register interpreter
`timescale 1ns/1ps
module hv_indirect_register_access_bench
    import hvi_pkg::*;
;
    // ----------------------------------------------------------------
    // Signals
    // ----------------------------------------------------------------
    logic        clk_sys, rst, read, write, fail_tx, fail_rd;
    logic [31:0] address, writedata, readdata, st, r;
    logic [3:0]  byteenable;
    logic        waitrequest, hv_sclk, hv_sdata_out, hv_sdata_oe, hv_line, drv_oe, drv_val;
    logic [7:0]  cfg_a, cfg_b, last_cmd;
    logic [7:0]  exp_rd [4];  // Expected read-back per code
    int          n_frames, nf, n_fail, cmp_count, cyc, min_per, last_t;
    localparam logic [31:0] ADDR_NONE = 32'hffff0808;  // Unmapped address
    localparam int          MIN_PER   = (HVI_CLK_HZ + HVI_LINK_HZ - 1) / HVI_LINK_HZ;

    // Wire level: device, then far side, else pull-down
    assign hv_line = hv_sdata_oe ? hv_sdata_out : (drv_oe ? drv_val : 1'b0);

    hvi_ctrl hvi_ctrl_i (.clk_sys(clk_sys), .rst(rst), .address(address), .read(read),
        .write(write), .byteenable(byteenable), .writedata(writedata), .readdata(readdata),
        .waitrequest(waitrequest), .hv_sclk(hv_sclk), .hv_sdata_out(hv_sdata_out),
        .hv_sdata_oe(hv_sdata_oe), .hv_sdata_in(hv_line));

    hvi_far_model hvi_far_model_i (.rst(rst), .hv_sclk(hv_sclk), .hv_line(hv_line),
        .fail_tx(fail_tx), .fail_rd(fail_rd), .drv_oe(drv_oe), .drv_val(drv_val),
        .cfg_a(cfg_a), .cfg_b(cfg_b), .last_cmd(last_cmd), .n_frames(n_frames));

    // ----------------------------------------------------------------
    // Clock, cycle counter, serial clock period monitor
    // ----------------------------------------------------------------
    initial
    begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end

    always @(posedge clk_sys) cyc <= cyc + 1;

    always @(posedge hv_sclk)
    begin
        if (last_t > 0 && cyc - last_t < min_per)
            min_per = cyc - last_t;
        last_t = cyc;
    end

    // ----------------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] expv);
        cmp_count++;
        if (seen !== expv)
        begin
            n_fail++;
            $display("MISMATCH t=%0t seen=%h expected=%h", $time, seen, expv);
        end
    endtask

    task automatic end_of_test();
        if (n_fail == 0 && cmp_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // One bus transfer, held until waitrequest is sampled low
    task automatic av_xfer(input logic wr, input logic [31:0] a, input logic [31:0] d,
                           output logic [31:0] q);
        @(posedge clk_sys);
        address   <= a;
        writedata <= d;
        write     <= wr;
        read      <= !wr;
        do
            @(posedge clk_sys);
        while (waitrequest !== 1'b0);
        q = readdata;
        write <= 1'b0;
        read  <= 1'b0;
    endtask

    task automatic av_write(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] q;
        av_xfer(1'b1, a, d, q);
    endtask

    task automatic av_read(input logic [31:0] a, output logic [31:0] q);
        av_xfer(1'b0, a, 32'h0, q);
    endtask

    // Poll until idle; status valid only then
    task automatic poll(output logic [31:0] s);
        int k;
        k = 0;
        do
        begin
            av_read(HVI_ADDR_CMD, s);
            k++;
        end
        while (s[0] !== 1'b0 && k < 200);
    endtask

    // Issue a command, check busy, await completion
    task automatic run_cmd(input logic [7:0] code, input logic exp_busy,
                           output logic [31:0] s);
        int t0;
        t0 = cyc;
        av_write(HVI_ADDR_CMD, {24'h0, code});
        av_read(HVI_ADDR_CMD, s);
        check({31'h0, s[0]}, {31'h0, exp_busy});
        poll(s);
        check(32'(cyc - t0 <= HVI_LAT_CYC), 32'h1);
    endtask

    // ----------------------------------------------------------------
    // Watchdog and main sequence
    // ----------------------------------------------------------------
    initial
    begin
        repeat (20000) @(posedge clk_sys);
        n_fail++;
        end_of_test();
    end

    initial
    begin
        rst = 1'b1; read = 1'b0; write = 1'b0; byteenable = 4'hf; address = 32'h0;
        writedata = 32'h0; fail_tx = 1'b0; fail_rd = 1'b0; cyc = 0; min_per = 1000;
        last_t = 0; n_fail = 0; cmp_count = 0;
        exp_rd = '{8'h5a, 8'ha5, 8'h3c, 8'hc3};
        repeat (8) @(posedge clk_sys);
        rst <= 1'b0;
        av_read(HVI_ADDR_DAT, r);
        check(r, {20'h0, HVI_DAT_RST});
        av_read(ADDR_NONE, r);
        check(r, 32'h0);
        // Writes to both config registers
        av_write(HVI_ADDR_DAT, 32'h5a);
        run_cmd(HVI_WR_CFG_A, 1'b1, st);
        check(st, 32'h6);
        check({24'h0, cfg_a}, 32'h5a);
        check({24'h0, last_cmd}, 32'h8);
        av_read(HVI_ADDR_DAT, r);
        check(r, 32'h85a);
        av_write(HVI_ADDR_DAT, 32'ha5);
        run_cmd(HVI_WR_CFG_B, 1'b1, st);
        check({24'h0, cfg_b}, 32'ha5);
        // Read back all four registers
        for (int i = 0; i < 4; i++)
        begin
            run_cmd(8'(i), 1'b1, st);
            check(st, 32'h6);
            av_read(HVI_ADDR_DAT, r);
            check(r, {20'h0, 4'(i), exp_rd[i]});
        end
        // Writes while busy are ignored
        nf = n_frames;
        av_write(HVI_ADDR_CMD, {24'h0, HVI_RD_STAT});
        av_write(HVI_ADDR_DAT, 32'h11);
        av_write(HVI_ADDR_CMD, {24'h0, HVI_WR_CFG_A});
        poll(st);
        check(32'(n_frames - nf), 32'h1);
        check({24'h0, cfg_a}, 32'h5a);
        // Unknown code, stray writes change nothing
        run_cmd(8'h05, 1'b0, st);
        av_write(ADDR_NONE, 32'h77);
        byteenable <= 4'h0;
        av_write(HVI_ADDR_DAT, 32'h99);
        byteenable <= 4'hf;
        check(32'(n_frames - nf), 32'h1);
        av_read(HVI_ADDR_DAT, r);
        check(r, 32'h23c);
        // Failed read-back, then failed transmit
        fail_rd <= 1'b1;
        run_cmd(HVI_RD_CFG_B, 1'b1, st);
        check(st, 32'h4);
        av_read(HVI_ADDR_DAT, r);
        check(r, 32'h23c);
        fail_rd <= 1'b0;
        fail_tx <= 1'b1;
        run_cmd(HVI_RD_CFG_A, 1'b1, st);
        check(st, 32'h2);
        fail_tx <= 1'b0;
        check(32'(min_per >= MIN_PER), 32'h1);
        // Mid-run reset restores reset state
        rst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
        av_read(HVI_ADDR_DAT, r);
        check(r, {20'h0, HVI_DAT_RST});
        av_read(HVI_ADDR_CMD, r);
        check(r, 32'h0);
        end_of_test();
    end
endmodule
